// >>> usp_pkg.sv
// Shared constants and state types for the serial host port
package usp_pkg;

    // ----------------------------------------
    // Status byte bit positions
    // ----------------------------------------
    localparam int ST_TX_HOLDING_FREE = 0;
    localparam int ST_RX_CHAR_AVAIL   = 1;
    localparam int ST_TX_ALL_SENT     = 2;
    localparam int ST_PARITY_FAULT    = 3;
    localparam int ST_OVERRUN_FAULT   = 4;
    localparam int ST_FRAMING_FAULT   = 5;
    localparam int ST_SYNC_FOUND      = 6;
    localparam int ST_DATASET_READY   = 7;

    // ----------------------------------------
    // Command byte bit positions
    // ----------------------------------------
    localparam int CMD_TX_ALLOW       = 0;
    localparam int CMD_TERM_READY     = 1;
    localparam int CMD_RX_ALLOW       = 2;
    localparam int CMD_SEND_BREAK     = 3;
    localparam int CMD_ERROR_CLEAR    = 4;
    localparam int CMD_REQ_SEND       = 5;
    localparam int CMD_INTERNAL_RESET = 6;
    localparam int CMD_ENTER_HUNT     = 7;

    // ----------------------------------------
    // Mode byte fields
    // ----------------------------------------
    localparam int MODE_BAUD_LSB      = 0;
    localparam int MODE_LEN_LSB       = 2;
    localparam int MODE_PARITY_EN     = 4;
    localparam int MODE_PARITY_EVEN   = 5;
    localparam int MODE_STOP_LSB      = 6;
    localparam logic [1:0] BAUD_SYNC  = 2'h0;
    localparam logic [1:0] BAUD_X1    = 2'h1;
    localparam logic [1:0] BAUD_X16   = 2'h2;
    localparam logic [1:0] BAUD_X64   = 2'h3;
    localparam logic [1:0] STOP_1     = 2'h1;
    localparam logic [1:0] STOP_1P5   = 2'h2;
    localparam logic [1:0] STOP_2     = 2'h3;

    // ----------------------------------------
    // Reset values, full byte mask and pin bundle width
    // ----------------------------------------
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [7:0] CMD_RST    = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [7:0] FULL_MASK  = 8'hFF;
    localparam int PIN_BITS           = 14;

    typedef struct packed {
        logic       expect_mode;
        logic [7:0] mode;
        logic [7:0] cmd;
        logic [7:0] tx_hold;
        logic       tx_full;
        logic [7:0] rx_buf;
        logic       rx_ready;
        logic       framing;
        logic       overrun;
        logic       parity;
        logic       sync_ff;
        logic       rd_prev;
        logic       wr_prev;
        logic [7:0] wr_data;
        logic       wr_cd;
        logic [7:0] dout;
        logic       doe;
        logic       rxa_pin;
        logic       txhf_pin;
        logic       txe_pin;
        logic       syn_pin;
        logic       rts_b;
        logic       dtr_b;
    } usp_state_t;

    typedef struct packed {
        logic [PIN_BITS-1:0] s1;
        logic [PIN_BITS-1:0] s2;
    } usp_sync_state_t;

endpackage

// >>> usp_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back
`timescale 1ns/1ps
interface usp_sync_if #(
    parameter int WIDTH = 14
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;
    modport user   (output raw, input clean);
    modport syncer (input raw, output clean);
endinterface

// >>> usp_pin_sync.sv
// Two-stage synchroniser for the asynchronous host and modem pins
`timescale 1ns/1ps
module usp_pin_sync #(
    parameter int WIDTH = 14
) (
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      ce,
    usp_sync_if.syncer     sif
);
    usp_pkg::usp_sync_state_t st_q;
    usp_pkg::usp_sync_state_t st_d;

    // Width check at elaboration: the bundle layout is fixed
    if (WIDTH != usp_pkg::PIN_BITS) begin
        $error("usp_pin_sync: WIDTH must match the pin bundle");
    end

    // Idle pins are high, so reset to ones keeps strobes inactive
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.s1 = sif.raw;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sif.clean = st_q.s2;

endmodule

// >>> usp_host_port.sv
// Host-side status, mode, command and character access of the serial interface
// ----------------------------------------
// How it works
// - Status read on control address, any time
// - Ready, empty, sync bits mirror their pins
// - Dataset-ready bit is inverted input pin
// - Framing fault from receiver sets flag
// - Unread character overwritten sets overrun flag
// - Parity mismatch from receiver sets flag
// - Holding-free status means buffer empty only
// - Holding-free pin also needs clear-to-send, enable
// - Mode byte fields drive the serial engines
// - Command byte sets enables and modem pins
// - Unused upper received bits read as zero
// - Ready pins usable as interrupt requests
// - Status read clears sync flop, no hunt
// - Error flags hold until error-clear command
// - Receive disable masks ready, inhibits errors
// ----------------------------------------
`timescale 1ns/1ps
module usp_host_port (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       cs_b,
    input  wire logic       rd_b,
    input  wire logic       wr_b,
    input  wire logic       c_d,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       dsr_b,
    input  wire logic       cts_b,
    output logic            rts_b,
    output logic            dtr_b,
    output logic            rx_char_available,
    output logic            tx_holding_free,
    output logic            tx_all_sent,
    output logic            sync_found,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char,
    input  wire logic       rx_frame_bad,
    input  wire logic       rx_parity_bad,
    input  wire logic       rx_sync_hit,
    input  wire logic       tx_take,
    input  wire logic       tx_shift_idle,
    output logic      [7:0] tx_char,
    output logic            tx_pending,
    output logic      [7:0] mode_byte,
    output logic      [7:0] cmd_byte
);
    usp_pkg::usp_state_t st_q;
    usp_pkg::usp_state_t st_d;

    usp_sync_if #(.WIDTH(usp_pkg::PIN_BITS)) pins ();

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    assign pins.raw = {cs_b, rd_b, wr_b, c_d, dsr_b, cts_b, data_in};

    usp_pin_sync #(
        .WIDTH (usp_pkg::PIN_BITS)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .sif   (pins)
    );

    logic       s_cs_b;
    logic       s_rd_b;
    logic       s_wr_b;
    logic       s_cd;
    logic       s_dsr_b;
    logic       s_cts_b;
    logic [7:0] s_data;
    assign {s_cs_b, s_rd_b, s_wr_b, s_cd, s_dsr_b, s_cts_b, s_data} = pins.clean;

    logic       rd_act;
    logic       wr_act;
    logic [7:0] status;
    logic [7:0] len_mask;
    logic       rx_allow;

    assign rd_act   = !s_cs_b && !s_rd_b;
    assign wr_act   = !s_cs_b && !s_wr_b;
    assign rx_allow = st_q.cmd[usp_pkg::CMD_RX_ALLOW];
    assign len_mask = usp_pkg::FULL_MASK >> (2'h3 - st_q.mode[usp_pkg::MODE_LEN_LSB +: 2]);

    // ----------------------------------------
    // Status byte
    // ----------------------------------------
    always_comb begin
        status = usp_pkg::BYTE_RST;
        status[usp_pkg::ST_TX_HOLDING_FREE] = !st_q.tx_full;
        status[usp_pkg::ST_RX_CHAR_AVAIL]   = st_q.rxa_pin;
        status[usp_pkg::ST_TX_ALL_SENT]     = st_q.txe_pin;
        status[usp_pkg::ST_SYNC_FOUND]      = st_q.syn_pin;
        status[usp_pkg::ST_PARITY_FAULT]    = st_q.parity;
        status[usp_pkg::ST_OVERRUN_FAULT]   = st_q.overrun;
        status[usp_pkg::ST_FRAMING_FAULT]   = st_q.framing;
        status[usp_pkg::ST_DATASET_READY]   = !s_dsr_b;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.rd_prev = rd_act;
            st_d.wr_prev = wr_act;
            st_d.doe     = rd_act;
            if (wr_act) begin
                st_d.wr_data = s_data;
                st_d.wr_cd   = s_cd;
            end

            // Error clear before sets, so a same-cycle event wins
            if (!wr_act && st_q.wr_prev && st_q.wr_cd && !st_q.expect_mode
                    && st_q.wr_data[usp_pkg::CMD_ERROR_CLEAR]) begin
                st_d.framing = 1'b0;
                st_d.overrun = 1'b0;
                st_d.parity  = 1'b0;
            end

            // Host reads, sampled once at strobe start
            if (rd_act && !st_q.rd_prev) begin
                if (s_cd) begin
                    st_d.dout = status;
                    st_d.sync_ff = 1'b0;
                end else begin
                    st_d.dout     = st_q.rx_buf & len_mask;
                    st_d.rx_ready = 1'b0;
                end
            end

            // Take before load, so a write in the same cycle is not lost
            if (tx_take) begin
                st_d.tx_full = 1'b0;
            end

            // Host writes act at strobe end, when data has settled
            if (!wr_act && st_q.wr_prev) begin
                if (!st_q.wr_cd) begin
                    st_d.tx_hold = st_q.wr_data;
                    st_d.tx_full = 1'b1;
                end else if (st_q.expect_mode) begin
                    st_d.mode        = st_q.wr_data;
                    st_d.expect_mode = 1'b0;
                end else if (st_q.wr_data[usp_pkg::CMD_INTERNAL_RESET]) begin
                    st_d.expect_mode = 1'b1;
                    st_d.cmd         = usp_pkg::CMD_RST;
                end else begin
                    st_d.cmd = st_q.wr_data;
                end
            end

            if (rx_char_valid) begin
                st_d.rx_buf   = rx_char;
                st_d.rx_ready = 1'b1;
                if (rx_allow) begin
                    if (st_q.rx_ready) begin
                        st_d.overrun = 1'b1;
                    end
                    if (rx_frame_bad) begin
                        st_d.framing = 1'b1;
                    end
                    if (rx_parity_bad) begin
                        st_d.parity = 1'b1;
                    end
                end
            end

            // Set after clear: a hit during a status read survives
            if (rx_sync_hit) begin
                st_d.sync_ff = 1'b1;
            end

            st_d.rxa_pin  = st_d.rx_ready && st_d.cmd[usp_pkg::CMD_RX_ALLOW];
            st_d.txhf_pin = !st_d.tx_full && !s_cts_b && st_d.cmd[usp_pkg::CMD_TX_ALLOW];
            st_d.txe_pin  = !st_d.tx_full && tx_shift_idle;
            st_d.syn_pin  = st_d.sync_ff;
            st_d.rts_b    = !st_d.cmd[usp_pkg::CMD_REQ_SEND];
            st_d.dtr_b    = !st_d.cmd[usp_pkg::CMD_TERM_READY];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q             <= '0;
            st_q.expect_mode <= 1'b1;
            st_q.mode        <= usp_pkg::MODE_RST;
            st_q.cmd         <= usp_pkg::CMD_RST;
            st_q.rts_b       <= 1'b1;
            st_q.dtr_b       <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign data_out          = st_q.dout;
    assign data_oe           = st_q.doe;
    assign rts_b             = st_q.rts_b;
    assign dtr_b             = st_q.dtr_b;
    assign rx_char_available = st_q.rxa_pin;
    assign tx_holding_free   = st_q.txhf_pin;
    assign tx_all_sent       = st_q.txe_pin;
    assign sync_found        = st_q.syn_pin;
    assign tx_char           = st_q.tx_hold;
    assign tx_pending        = st_q.tx_full;
    assign mode_byte         = st_q.mode;
    assign cmd_byte          = st_q.cmd;

endmodule

// >>> usp_host_port_monitor.sv
// Concurrent checks on the serial host port pins
`timescale 1ns/1ps
module usp_host_port_monitor (
    input logic       clk,
    input logic       rst_b,
    input logic       cs_b,
    input logic       rd_b,
    input logic       cts_b,
    input logic       data_oe,
    input logic       tx_holding_free,
    input logic       tx_all_sent,
    input logic       tx_pending,
    input logic       tx_take,
    input logic       tx_shift_idle,
    input logic       rts_b,
    input logic       dtr_b,
    input logic       sync_found,
    input logic       rx_sync_hit,
    input logic       rx_char_available,
    input logic [7:0] cmd_byte
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Pin relations
    // ----------------------------------------
    oe_cause_a: assert property ($rose(data_oe) |-> $past(!rd_b && !cs_b, 2))
        else $error("data bus driven without a read");
    oe_release_a: assert property (rd_b [*5] |-> !data_oe)
        else $error("data bus still driven after read ended");
    pin_free_a: assert property (tx_holding_free |-> !tx_pending && cmd_byte[0])
        else $error("holding free pin high while full or disabled");
    cts_gate_a: assert property (cts_b [*6] |-> !tx_holding_free)
        else $error("holding free pin high with clear-to-send off");
    all_sent_a: assert property (tx_all_sent |-> !tx_pending && $past(tx_shift_idle))
        else $error("all sent pin high while busy");
    holding_take_a: assert property (tx_take |=> !tx_pending)
        else $error("holding not emptied by take");
    modem_follow_a: assert property ({rts_b, dtr_b} == ~{cmd_byte[5], cmd_byte[1]})
        else $error("modem pins do not follow command");
    rx_mask_a: assert property (rx_char_available |-> cmd_byte[2])
        else $error("receive ready shown while receive disabled");
    sync_set_a: assert property ($rose(sync_found) |-> $past(rx_sync_hit))
        else $error("sync pin rose without a hit");
    cover property ($rose(data_oe));
    cover property ($fell(tx_pending));
    cover property ($fell(sync_found));
endmodule

bind usp_host_port usp_host_port_monitor u_mon (.clk, .rst_b, .cs_b, .rd_b, .cts_b, .data_oe,
    .tx_holding_free, .tx_all_sent, .tx_pending, .tx_take, .tx_shift_idle, .rts_b, .dtr_b,
    .sync_found, .rx_sync_hit, .rx_char_available, .cmd_byte);

// >>> usp_engine_model.sv
// Behavioural stand-in for the receive and transmit shift engines
`timescale 1ns/1ps
module usp_engine_model (
    input  logic       clk,
    output logic       rx_char_valid,
    output logic [7:0] rx_char,
    output logic       rx_frame_bad,
    output logic       rx_parity_bad,
    output logic       rx_sync_hit,
    output logic       tx_take,
    output logic       tx_shift_idle
);
    initial begin
        {rx_char_valid, rx_frame_bad, rx_parity_bad, rx_sync_hit, tx_take} = 5'h00;
        rx_char = 8'h00;
        tx_shift_idle = 1'h1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [7:0] ch, input logic fe, input logic pe);
        step(1);
        rx_char_valid = 1'h1;
        rx_char = ch;
        {rx_frame_bad, rx_parity_bad} = {fe, pe};
        step(1);
        rx_char_valid = 1'h0;
        // Qualifiers scrambled once the pulse is over
        rx_char = ~ch;
        {rx_frame_bad, rx_parity_bad} = ~{fe, pe};
        step(3);
    endtask
    task automatic sync_hit;
        step(1);
        rx_sync_hit = 1'h1;
        step(1);
        rx_sync_hit = 1'h0;
        step(3);
    endtask
    task automatic take;
        step(1);
        tx_take = 1'h1;
        tx_shift_idle = 1'h0;
        step(1);
        tx_take = 1'h0;
        step(3);
    endtask
    task automatic finish;
        tx_shift_idle = 1'h1;
        step(3);
    endtask
endmodule

// >>> usart_status_and_host_port_tb.sv
// Self-checking bench for the serial host port
`timescale 1ns/1ps
module usart_status_and_host_port_tb;
    logic       clk, rst_b, ce, cs_b, rd_b, wr_b, c_d, dsr_b, cts_b;
    logic       data_oe, rts_b, dtr_b, rx_char_available, tx_holding_free, tx_all_sent;
    logic       sync_found, tx_pending, rx_char_valid, rx_frame_bad, rx_parity_bad;
    logic       rx_sync_hit, tx_take, tx_shift_idle;
    logic [7:0] data_in, data_out, rx_char, tx_char, mode_byte, cmd_byte, st;
    int         bad_count, num_checks;

    usp_host_port uut (.clk, .rst_b, .ce, .cs_b, .rd_b, .wr_b, .c_d, .data_in, .data_out,
        .data_oe, .dsr_b, .cts_b, .rts_b, .dtr_b, .rx_char_available, .tx_holding_free,
        .tx_all_sent, .sync_found, .rx_char_valid, .rx_char, .rx_frame_bad, .rx_parity_bad,
        .rx_sync_hit, .tx_take, .tx_shift_idle, .tx_char, .tx_pending, .mode_byte, .cmd_byte);
    usp_engine_model eng (.clk, .rx_char_valid, .rx_char, .rx_frame_bad, .rx_parity_bad,
        .rx_sync_hit, .tx_take, .tx_shift_idle);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // Strobe held six cycles, six idle after, so synchronised timing is met
    task automatic acc(input logic cd, input logic w, input logic [7:0] d, output logic [7:0] q);
        c_d = cd;
        data_in = d;
        cs_b = 1'h0;
        rd_b = w;
        wr_b = !w;
        tick(6);
        q = data_out;
        {cs_b, rd_b, wr_b} = 3'h7;
        data_in = ~d;
        tick(6);
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        close_out;
    end
    initial begin
        {rst_b, cs_b, rd_b, wr_b, c_d, dsr_b, cts_b} = 7'h3E;
        ce = 1'h1;
        data_in = 8'h00;
        bad_count = 0;
        num_checks = 0;
        tick(20);
        rst_b = 1'h1;
        tick(2);
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h05, "reset status");
        chk({5'h00, rts_b, dtr_b, data_oe}, 8'h06, "reset pins");
        done("reset");
        acc(1'h1, 1'h1, 8'hB6, st);
        acc(1'h1, 1'h1, 8'h27, st);
        chk(mode_byte, 8'hB6, "mode");
        chk({6'h00, mode_byte[1:0]}, {6'h00, usp_pkg::BAUD_X16}, "baud");
        chk({6'h00, mode_byte[3:2]}, 8'h01, "six bits");
        chk({6'h00, mode_byte[5:4]}, 8'h03, "even parity");
        chk({6'h00, mode_byte[7:6]}, {6'h00, usp_pkg::STOP_1P5}, "stop");
        chk({4'h0, rts_b, dtr_b, cmd_byte[2], cmd_byte[0]}, 8'h03, "command");
        done("init");
        cts_b = 1'h1;
        tick(6);
        chk({7'h00, tx_holding_free}, 8'h00, "pin with cts off");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h05, "status with cts off");
        cts_b = 1'h0;
        tick(6);
        chk({7'h00, tx_holding_free}, 8'h01, "pin free");
        acc(1'h0, 1'h1, 8'h2D, st);
        chk({6'h00, tx_pending, tx_holding_free}, 8'h02, "holding full");
        chk(tx_char, 8'h2D, "held char");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h00, "status full");
        eng.take();
        chk({5'h00, tx_pending, tx_all_sent, tx_holding_free}, 8'h01, "shifting");
        eng.finish();
        chk({7'h00, tx_all_sent}, 8'h01, "all sent");
        done("transmit");
        eng.send(8'hED, 1'h1, 1'h1);
        eng.send(8'hFA, 1'h0, 1'h0);
        chk({7'h00, rx_char_available}, 8'h01, "rx pin");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h3F, "error status");
        acc(1'h0, 1'h0, 8'h00, st);
        chk(st, 8'h3A, "masked char");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h3D, "errors held");
        acc(1'h1, 1'h1, 8'h37, st);
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h05, "errors cleared");
        done("receive");
        eng.sync_hit();
        chk({7'h00, sync_found}, 8'h01, "sync pin");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h45, "sync status");
        chk({7'h00, sync_found}, 8'h00, "sync pin cleared");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h05, "sync cleared");
        dsr_b = 1'h0;
        tick(4);
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h85, "dataset ready");
        dsr_b = 1'h1;
        done("sync and dataset");
        acc(1'h1, 1'h1, 8'h23, st);
        eng.send(8'h11, 1'h1, 1'h0);
        chk({6'h00, rx_char_available, rts_b}, 8'h00, "receive off pins");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h05, "receive off status");
        acc(1'h1, 1'h1, 8'h27, st);
        chk({7'h00, rx_char_available}, 8'h01, "receive on pin");
        acc(1'h1, 1'h0, 8'h00, st);
        chk(st, 8'h07, "errors still inhibited");
        acc(1'h0, 1'h0, 8'h00, st);
        chk(st, 8'h11, "char kept while off");
        done("receive off");
        // Frozen block must ignore a whole command write
        ce = 1'h0;
        acc(1'h1, 1'h1, 8'h00, st);
        chk(cmd_byte, 8'h27, "frozen command");
        chk({6'h00, rts_b, dtr_b}, 8'h00, "frozen modem pins");
        ce = 1'h1;
        tick(3);
        done("clock enable");
        acc(1'h1, 1'h1, 8'h40, st);
        chk(cmd_byte, 8'h00, "internal reset");
        chk({6'h00, rts_b, dtr_b}, 8'h03, "modem pins off");
        acc(1'h1, 1'h1, 8'h7A, st);
        acc(1'h1, 1'h1, 8'h25, st);
        chk(mode_byte, 8'h7A, "mode again");
        chk(cmd_byte, 8'h25, "command again");
        done("internal reset");
        close_out;
    end
endmodule
